/* common/ptm_pkg.sv */
// Constants for the trigger match-select slice
// Function
// - Channel 2 match mode is three bits at 10..8, read and write.
// - Codes 000 and 111 give no channel 2 trigger.
// - Code 001 triggers on compare match while counting down.
// - Code 010 triggers on up-count match, 011 on either direction.
// - Code 100 triggers at carrier peak regardless of compare value.
// - Code 101 triggers at carrier bottom.
// - Code 110 triggers at both carrier peak and bottom.
// - Sawtooth carrier turns code 001 into an up-count match trigger.
// - Sawtooth carrier turns code 101 into a peak trigger.
// - Triangle, code 011, compare 0x0001 gives one trigger per period.
// - Bit 7 selects channel 1 update; zero loads buffer on carrier event.
// - Bit 7 set copies a channel 1 compare write to the buffer at once.
// - With the PWM unit disabled, buffers always update at once.
package ptm_pkg;
    localparam int CMP_W = 16;
    localparam int ADDR_W = 4;
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CH1_CMP = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CH2_CMP = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CH1_BUF = 4'hC;
    // Trigger control fields
    localparam int CH1_IMM_BIT = 7;
    localparam int CH2_MODE_LSB = 8;
    localparam int CH2_MODE_MSB = 10;
    localparam int CH2_IMM_BIT = 11;
    // Reset values and the single-compare value
    localparam logic [CMP_W-1:0] CMP_RST = 16'h0000;
    localparam logic [CMP_W-1:0] CMP_ONE = 16'h0001;
    localparam logic [CMP_W-1:0] CNT_BOTTOM = 16'h0000;
    // Match-mode codes
    localparam logic [2:0] MD_OFF0 = 3'h0;
    localparam logic [2:0] MD_DOWN = 3'h1;
    localparam logic [2:0] MD_UP = 3'h2;
    localparam logic [2:0] MD_BOTH = 3'h3;
    localparam logic [2:0] MD_PEAK = 3'h4;
    localparam logic [2:0] MD_BOT = 3'h5;
    localparam logic [2:0] MD_PKBT = 3'h6;
    localparam logic [2:0] MD_OFF7 = 3'h7;
endpackage

/* src/ptm_trig_decode.sv */
// Trigger condition decode for one compare channel
`timescale 1ns/1ps
module ptm_trig_decode
    import ptm_pkg::*;
(
    input wire logic [2:0] mode_i,
    input wire logic sawtooth_i,
    input wire logic match_i,
    input wire logic up_i,
    input wire logic peak_i,
    input wire logic bottom_i,
    input wire logic single_cmp_i,
    output logic fire_o
);
    // Mode selection of trigger condition
    always_comb begin
        case (mode_i)
            MD_DOWN: fire_o = match_i & (sawtooth_i ? up_i : ~up_i);
            MD_UP: fire_o = match_i & up_i;
            MD_BOTH: fire_o = match_i & (~single_cmp_i | up_i);
            MD_PEAK: fire_o = peak_i;
            MD_BOT: fire_o = sawtooth_i ? peak_i : bottom_i;
            MD_PKBT: fire_o = peak_i | bottom_i;
            default: fire_o = 1'b0;
        endcase
    end
endmodule // ptm_trig_decode

/* src/ptm_trigger_select.sv */
// Trigger match-mode select and compare buffer update for one PWM slice
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module ptm_trigger_select
    import ptm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic [CMP_W-1:0] carrier_cnt_i,
    input wire logic [CMP_W-1:0] carrier_period_i,
    input wire logic carrier_mode_i,
    input wire logic pwm_enable_i,
    output logic trig_ch1_o,
    output logic trig_ch2_o
);
    logic [2:0] trig_ch2_match_mode_reg;
    logic trig_ch1_immediate_load_reg;
    logic trig_ch2_immediate_load_reg;
    logic [CMP_W-1:0] trig_ch1_compare_value_reg;
    logic [CMP_W-1:0] trig_ch2_compare_value_reg;
    logic [CMP_W-1:0] ch1_buf_reg;
    logic [CMP_W-1:0] ch2_buf_reg;
    logic [CMP_W-1:0] cnt_prev_reg;
    logic cnt_valid_reg;
    logic up_dir;
    logic at_peak;
    logic at_bottom;
    logic sawtooth;
    logic ch1_fire;
    logic ch2_fire;
    logic wr_ctrl;
    logic wr_ch1;
    logic wr_ch2;
    logic [31:0] rdata_next;
    logic new_cnt;
    logic ch1_match;
    logic ch2_match;

    // Fresh count: value changed while the unit stayed enabled over two edges
    function automatic logic fresh_count(input logic [CMP_W-1:0] cnt, input logic [CMP_W-1:0] prev,
        input logic valid, input logic en);
        fresh_count = valid && en && cnt != prev;
    endfunction

    assign sawtooth = ~carrier_mode_i;
    assign wr_ctrl = wr_i && addr_i == OFS_TRIG_CTRL;
    assign wr_ch1 = wr_i && addr_i == OFS_CH1_CMP;
    assign wr_ch2 = wr_i && addr_i == OFS_CH2_CMP;

    // Control word fields
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_ch2_match_mode_reg <= MD_OFF0;
            trig_ch1_immediate_load_reg <= 1'b0;
            trig_ch2_immediate_load_reg <= 1'b0;
        end else if (wr_ctrl) begin
            trig_ch2_match_mode_reg <= wdata_i[CH2_MODE_MSB:CH2_MODE_LSB];
            trig_ch1_immediate_load_reg <= wdata_i[CH1_IMM_BIT];
            trig_ch2_immediate_load_reg <= wdata_i[CH2_IMM_BIT];
        end
    end

    // Compare registers written by software
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_ch1_compare_value_reg <= CMP_RST;
            trig_ch2_compare_value_reg <= CMP_RST;
        end else begin
            if (wr_ch1) begin
                trig_ch1_compare_value_reg <= wdata_i[CMP_W-1:0];
            end
            if (wr_ch2) begin
                trig_ch2_compare_value_reg <= wdata_i[CMP_W-1:0];
            end
        end
    end

    // Carrier direction from previous count
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_prev_reg <= CNT_BOTTOM;
            cnt_valid_reg <= 1'b0;
        end else begin
            cnt_prev_reg <= carrier_cnt_i;
            cnt_valid_reg <= pwm_enable_i;
        end
    end

    // Sawtooth always counts up; triangle direction from count change
    assign up_dir = sawtooth ? 1'b1 :
        (carrier_cnt_i > cnt_prev_reg) || (carrier_cnt_i == CNT_BOTTOM);
    assign new_cnt = fresh_count(carrier_cnt_i, cnt_prev_reg, cnt_valid_reg, pwm_enable_i);
    assign at_peak = new_cnt && carrier_cnt_i == carrier_period_i;
    assign at_bottom = new_cnt && carrier_cnt_i == CNT_BOTTOM;

    // Compare hits against the active buffers
    assign ch1_match = new_cnt && carrier_cnt_i == ch1_buf_reg;
    assign ch2_match = new_cnt && carrier_cnt_i == ch2_buf_reg;

    // Compare buffers: immediate or at carrier event
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch1_buf_reg <= CMP_RST;
            ch2_buf_reg <= CMP_RST;
        end else begin
            if (trig_ch1_immediate_load_reg || !pwm_enable_i) begin
                ch1_buf_reg <= trig_ch1_compare_value_reg;
            end else if (at_bottom || (sawtooth && at_peak)) begin
                ch1_buf_reg <= trig_ch1_compare_value_reg;
            end
            if (trig_ch2_immediate_load_reg || !pwm_enable_i) begin
                ch2_buf_reg <= trig_ch2_compare_value_reg;
            end else if (at_bottom || (sawtooth && at_peak)) begin
                ch2_buf_reg <= trig_ch2_compare_value_reg;
            end
        end
    end

    // Channel 1 fires on either-direction match; channel 2 by mode
    ptm_trig_decode u_dec1 (
        .mode_i(MD_BOTH),
        .sawtooth_i(sawtooth),
        .match_i(ch1_match),
        .up_i(up_dir),
        .peak_i(at_peak),
        .bottom_i(at_bottom),
        .single_cmp_i(!sawtooth && ch1_buf_reg == CMP_ONE),
        .fire_o(ch1_fire)
    );
    ptm_trig_decode u_dec2 (
        .mode_i(trig_ch2_match_mode_reg),
        .sawtooth_i(sawtooth),
        .match_i(ch2_match),
        .up_i(up_dir),
        .peak_i(at_peak),
        .bottom_i(at_bottom),
        .single_cmp_i(!sawtooth && ch2_buf_reg == CMP_ONE),
        .fire_o(ch2_fire)
    );

    // Trigger pulses, one cycle each
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_ch1_o <= 1'b0;
            trig_ch2_o <= 1'b0;
        end else begin
            trig_ch1_o <= ch1_fire;
            trig_ch2_o <= ch2_fire;
        end
    end

    // Read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (addr_i)
            OFS_TRIG_CTRL: begin
                rdata_next[CH2_MODE_MSB:CH2_MODE_LSB] = trig_ch2_match_mode_reg;
                rdata_next[CH1_IMM_BIT] = trig_ch1_immediate_load_reg;
                rdata_next[CH2_IMM_BIT] = trig_ch2_immediate_load_reg;
            end
            OFS_CH1_CMP: rdata_next[CMP_W-1:0] = trig_ch1_compare_value_reg;
            OFS_CH2_CMP: rdata_next[CMP_W-1:0] = trig_ch2_compare_value_reg;
            OFS_CH1_BUF: rdata_next[CMP_W-1:0] = ch1_buf_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data one cycle after strobe, zero otherwise
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end

    // Assertions
    property p_off_silent;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_OFF0 || trig_ch2_match_mode_reg == MD_OFF7) |=> !trig_ch2_o;
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("trigger in disabled mode");

    property p_peak;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_PEAK && at_peak) |=> trig_ch2_o;
    endproperty
    a_peak: assert property (p_peak) else $error("missed peak trigger");

    property p_pkbt;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_PKBT && (at_peak || at_bottom)) |=> trig_ch2_o;
    endproperty
    a_pkbt: assert property (p_pkbt) else $error("missed peak or bottom trigger");

    property p_pulse;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        trig_ch2_o |=> !trig_ch2_o || ($past(carrier_cnt_i) != $past(carrier_cnt_i, 2));
    endproperty
    a_pulse: assert property (p_pulse) else $error("trigger not a pulse");

    property p_imm;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (wr_ch1 && trig_ch1_immediate_load_reg) |=> ##1 ch1_buf_reg == $past(wdata_i[CMP_W-1:0], 2);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate load late");

    property p_disabled_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!pwm_enable_i && wr_ch2) |=> !pwm_enable_i |=> ch2_buf_reg == $past(trig_ch2_compare_value_reg);
    endproperty
    a_disabled_load: assert property (p_disabled_load) else $error("disabled unit not loading");

    property p_sync_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (pwm_enable_i && !trig_ch1_immediate_load_reg && !at_bottom && !at_peak) |=> $stable(ch1_buf_reg);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync buffer changed early");

    property p_saw_bot;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sawtooth && trig_ch2_match_mode_reg == MD_BOT && at_bottom && !at_peak) |=> !trig_ch2_o;
    endproperty
    a_saw_bot: assert property (p_saw_bot) else $error("sawtooth bottom trigger fired");

    // Synchronous load point and channel 2 compare hit
    sequence s_sync_event;
        pwm_enable_i && !trig_ch1_immediate_load_reg && (at_bottom || (sawtooth && at_peak));
    endsequence

    sequence s_ch2_hit;
        ch2_match;
    endsequence

    property p_down_tri;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sawtooth && trig_ch2_match_mode_reg == MD_DOWN && !up_dir) ##0 s_ch2_hit |=> trig_ch2_o;
    endproperty
    a_down_tri: assert property (p_down_tri) else $error("missed down-count trigger");

    property p_down_no_up;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sawtooth && trig_ch2_match_mode_reg == MD_DOWN && up_dir) |=> !trig_ch2_o;
    endproperty
    a_down_no_up: assert property (p_down_no_up) else $error("down mode fired counting up");

    property p_up;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_UP && up_dir) ##0 s_ch2_hit |=> trig_ch2_o;
    endproperty
    a_up: assert property (p_up) else $error("missed up-count trigger");

    property p_up_no_down;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_UP && !(ch2_match && up_dir)) |=> !trig_ch2_o;
    endproperty
    a_up_no_down: assert property (p_up_no_down) else $error("up mode fired without up match");

    property p_both;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_BOTH && (sawtooth || ch2_buf_reg != CMP_ONE)) ##0 s_ch2_hit
            |=> trig_ch2_o;
    endproperty
    a_both: assert property (p_both) else $error("missed either-direction trigger");

    property p_one_per_period;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sawtooth && trig_ch2_match_mode_reg == MD_BOTH && ch2_buf_reg == CMP_ONE && !up_dir) |=> !trig_ch2_o;
    endproperty
    a_one_per_period: assert property (p_one_per_period) else $error("second trigger in period");

    property p_peak_only;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch2_match_mode_reg == MD_PEAK && !at_peak) |=> !trig_ch2_o;
    endproperty
    a_peak_only: assert property (p_peak_only) else $error("peak mode fired off peak");

    property p_bottom;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!sawtooth && trig_ch2_match_mode_reg == MD_BOT && at_bottom) |=> trig_ch2_o;
    endproperty
    a_bottom: assert property (p_bottom) else $error("missed bottom trigger");

    property p_saw_up;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sawtooth && trig_ch2_match_mode_reg == MD_DOWN) ##0 s_ch2_hit |=> trig_ch2_o;
    endproperty
    a_saw_up: assert property (p_saw_up) else $error("missed sawtooth match trigger");

    property p_saw_peak;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (sawtooth && trig_ch2_match_mode_reg == MD_BOT && at_peak) |=> trig_ch2_o;
    endproperty
    a_saw_peak: assert property (p_saw_peak) else $error("missed sawtooth peak trigger");

    property p_ch1_match;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ch1_match && (sawtooth || ch1_buf_reg != CMP_ONE)) |=> trig_ch1_o;
    endproperty
    a_ch1_match: assert property (p_ch1_match) else $error("missed channel 1 trigger");

    property p_ch1_pulse;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        trig_ch1_o |=> !trig_ch1_o || ($past(carrier_cnt_i) != $past(carrier_cnt_i, 2));
    endproperty
    a_ch1_pulse: assert property (p_ch1_pulse) else $error("channel 1 trigger not a pulse");

    property p_ctrl_write;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        wr_ctrl |=> trig_ch2_match_mode_reg == $past(wdata_i[CH2_MODE_MSB:CH2_MODE_LSB]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("mode field not written");

    property p_ctrl_read;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_i && addr_i == OFS_TRIG_CTRL) |=> rdata_o[CH2_MODE_MSB:CH2_MODE_LSB] == $past(trig_ch2_match_mode_reg);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("mode field read wrong");

    property p_rdata_idle;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !rd_i |=> rdata_o == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

    property p_sync_load;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        s_sync_event |=> ch1_buf_reg == $past(trig_ch1_compare_value_reg);
    endproperty
    a_sync_load: assert property (p_sync_load) else $error("sync load missed carrier event");

    property p_imm_follow;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (trig_ch1_immediate_load_reg && pwm_enable_i) |=> ch1_buf_reg == $past(trig_ch1_compare_value_reg);
    endproperty
    a_imm_follow: assert property (p_imm_follow) else $error("immediate buffer not following");

    property p_disabled_ch1;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pwm_enable_i |=> ch1_buf_reg == $past(trig_ch1_compare_value_reg);
    endproperty
    a_disabled_ch1: assert property (p_disabled_ch1) else $error("disabled unit not loading ch1");
endmodule // ptm_trigger_select

/* tb/tb_pwm_trigger_match_select.sv */
// Self-checking bench for the trigger match-select slice
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module tb_pwm_trigger_match_select;
    import ptm_pkg::*;
    typedef struct {
        logic [2:0] md;
        logic tri_w;
        logic [CMP_W-1:0] cmp;
        logic [CMP_W-1:0] p;
        logic [CMP_W-1:0] c;
        logic exp;
    } ptm_row_s;

    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [CMP_W-1:0] carrier_cnt_i = 16'h0000;
    logic [CMP_W-1:0] carrier_period_i = 16'h0010;
    logic carrier_mode_i = 1'b1;
    logic pwm_enable_i = 1'b0;
    logic trig_ch1_o;
    logic trig_ch2_o;
    logic [31:0] rd_val;
    int err_total = 0;
    int num_checks = 0;

    // Ordinary cases: mode, triangle, compare, previous count, count, expected ch2 trigger
    ptm_row_s rows [19] = '{
        '{MD_OFF0, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h0},
        '{MD_OFF7, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h0},
        '{MD_DOWN, 1'h1, 16'h0005, 16'h0006, 16'h0005, 1'h1},
        '{MD_DOWN, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h0},
        '{MD_UP, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h1},
        '{MD_UP, 1'h1, 16'h0005, 16'h0006, 16'h0005, 1'h0},
        '{MD_BOTH, 1'h1, 16'h0005, 16'h0006, 16'h0005, 1'h1},
        '{MD_BOTH, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h1},
        '{MD_PEAK, 1'h1, 16'h0005, 16'h000F, 16'h0010, 1'h1},
        '{MD_PEAK, 1'h1, 16'h0005, 16'h0004, 16'h0005, 1'h0},
        '{MD_BOT, 1'h1, 16'h0005, 16'h0001, 16'h0000, 1'h1},
        '{MD_BOT, 1'h1, 16'h0005, 16'h000F, 16'h0010, 1'h0},
        '{MD_PKBT, 1'h1, 16'h0005, 16'h000F, 16'h0010, 1'h1},
        '{MD_PKBT, 1'h1, 16'h0005, 16'h0001, 16'h0000, 1'h1},
        '{MD_DOWN, 1'h0, 16'h0005, 16'h0004, 16'h0005, 1'h1},
        '{MD_BOT, 1'h0, 16'h0005, 16'h000F, 16'h0010, 1'h1},
        '{MD_BOT, 1'h0, 16'h0005, 16'h0010, 16'h0000, 1'h0},
        '{MD_BOTH, 1'h1, 16'h0001, 16'h0000, 16'h0001, 1'h1},
        '{MD_BOTH, 1'h1, 16'h0001, 16'h0002, 16'h0001, 1'h0}
    };

    ptm_trigger_select i_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .carrier_cnt_i(carrier_cnt_i),
        .carrier_period_i(carrier_period_i), .carrier_mode_i(carrier_mode_i),
        .pwm_enable_i(pwm_enable_i), .trig_ch1_o(trig_ch1_o), .trig_ch2_o(trig_ch2_o)
    );

    // Clock at 125 MHz
    always #4 ref_clk_i = ~ref_clk_i;

    // One-cycle register write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle register read, data taken in the following cycle
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask

    // Counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Guard against a hang
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_total++;
        stop_test();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        wr(OFS_CH1_CMP, 32'h0000_0009);
        foreach (rows[i]) begin
            @(posedge ref_clk_i);
            pwm_enable_i <= 1'b0;
            carrier_mode_i <= rows[i].tri_w;
            wr(OFS_TRIG_CTRL, 32'h0000_0800 | (32'(rows[i].md) << CH2_MODE_LSB));
            wr(OFS_CH2_CMP, {16'h0000, rows[i].cmp});
            @(posedge ref_clk_i);
            carrier_cnt_i <= rows[i].p;
            pwm_enable_i <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            carrier_cnt_i <= rows[i].c;
            @(posedge ref_clk_i);
            #1;
            `CHK(trig_ch2_o, rows[i].exp)
            `CHK(trig_ch1_o, 1'b0)
            @(posedge ref_clk_i);
            #1;
            `CHK(trig_ch2_o, 1'b0)
        end
        // Reset in mid-run clears the control word
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        pwm_enable_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(OFS_TRIG_CTRL);
        `CHK(rd_val, 32'h0000_0000)
        // Mode field readback, unmapped write ignored and read as zero
        wr(OFS_TRIG_CTRL, 32'h0000_0500);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(OFS_TRIG_CTRL);
        `CHK(rd_val, 32'h0000_0500)
        rd(4'h2);
        `CHK(rd_val, 32'h0000_0000)
        // Disabled unit loads the buffer at once
        @(posedge ref_clk_i);
        carrier_cnt_i <= 16'h0005;
        wr(OFS_CH1_CMP, 32'h0000_1234);
        rd(OFS_CH1_BUF);
        `CHK(rd_val, 32'h0000_1234)
        // Enabled, synchronous load waits for the carrier bottom
        @(posedge ref_clk_i);
        pwm_enable_i <= 1'b1;
        wr(OFS_CH1_CMP, 32'h0000_0ABC);
        rd(OFS_CH1_BUF);
        `CHK(rd_val, 32'h0000_1234)
        @(posedge ref_clk_i);
        carrier_cnt_i <= 16'h0000;
        rd(OFS_CH1_BUF);
        `CHK(rd_val, 32'h0000_0ABC)
        // Immediate load bit copies the write at once
        wr(OFS_TRIG_CTRL, 32'h0000_0080);
        wr(OFS_CH1_CMP, 32'h0000_0DEF);
        rd(OFS_CH1_BUF);
        `CHK(rd_val, 32'h0000_0DEF)
        // Channel 1 fires on an up-count match with its buffer
        @(posedge ref_clk_i);
        carrier_cnt_i <= 16'h0DEF;
        @(posedge ref_clk_i);
        #1;
        `CHK(trig_ch1_o, 1'b1)
        stop_test();
    end
endmodule // tb_pwm_trigger_match_select
